// File: pkg/iac_pkg.sv
// Package: constants and types for the input alarm and pulse counter block
package iac_pkg;

   // Digital input types
   typedef enum logic [2:0] {
      IAC_DIN_DISABLED = 3'h0,
      IAC_DIN_NC       = 3'h1,
      IAC_DIN_NO       = 3'h2,
      IAC_DIN_CHANGE   = 3'h3,
      IAC_DIN_COUNTER  = 3'h4,
      IAC_DIN_ARMSW    = 3'h5
   } iac_din_type;

   // Analog input types
   typedef enum logic [1:0] {
      IAC_AIN_DISABLED = 2'h0,
      IAC_AIN_V0_5     = 2'h1,
      IAC_AIN_MA0_20   = 2'h2,
      IAC_AIN_MA4_20   = 2'h3
   } iac_ain_type;

   // Event kinds carried to the messaging unit
   typedef enum logic [2:0] {
      IAC_EV_NONE     = 3'h0,
      IAC_EV_ALARM    = 3'h1,
      IAC_EV_RECOVERY = 3'h2,
      IAC_EV_CHANGE   = 3'h3,
      IAC_EV_STEP     = 3'h4,
      IAC_EV_TOTAL    = 3'h5,
      IAC_EV_HIGH     = 3'h6,
      IAC_EV_LOW      = 3'h7
   } iac_event_type;

   // Channel counts and widths
   localparam int IAC_NUM_DIN     = 8;
   localparam int IAC_NUM_AIN     = 6;
   localparam int IAC_VERIFY_W    = 16;
   localparam int IAC_COUNT_W     = 32;
   localparam int IAC_AIN_W       = 32;
   localparam int IAC_CHAN_W      = 4;

   // Fixed channel roles
   localparam int IAC_COUNTER_CH  = 0;
   localparam int IAC_ARMSW_CH    = 1;

   // Discrete input map, function code 02, one bit per address
   localparam logic [7:0] IAC_FC_READ_DISCRETE = 8'h02;
   localparam logic [3:0] IAC_DIN0_STATE_ADDR  = 4'h0;
   localparam logic [3:0] IAC_DIN7_STATE_ADDR  = 4'h7;

   // Fixed climate sensor ranges, hundredths
   localparam logic signed [15:0] IAC_TEMP_MAX_X100 = 16'sd8000;
   localparam logic signed [15:0] IAC_TEMP_MIN_X100 = -16'sd4000;
   localparam logic signed [15:0] IAC_HUM_MAX_X100  = 16'sd10000;
   localparam logic signed [15:0] IAC_HUM_MIN_X100  = 16'sd0;

   // Verify time tick: 1 ms unit at 100 MHz
   localparam int IAC_CLK_MHZ          = 100;
   localparam int IAC_VERIFY_UNIT_US   = 1000;
   localparam int IAC_VERIFY_TICK_CYC  = IAC_VERIFY_UNIT_US * IAC_CLK_MHZ;

endpackage

// File: test/iac_chk.sv
// Checker: port assertions for the alarm and counter block
`timescale 1ns/1ns
module iac_chk
   import iac_pkg::*;
(
   // Clock and reset
   input wire logic        clk_sys,
   input wire logic        rst,
   // Inputs watched
   input wire logic [7:0]  din_closed,
   input wire logic [23:0] din_type_cfg,
   input wire logic [31:0] count_initial,
   input wire logic [7:0]  di_func,
   input wire logic [3:0]  di_addr,
   input wire logic        di_rd,
   // Outputs watched
   input wire logic        di_valid,
   input wire logic        di_bit,
   input wire logic        di_err,
   input wire logic [7:0]  din_state,
   input wire logic        armed,
   input wire logic [31:0] count_value,
   input wire logic        ev_valid,
   input wire logic [3:0]  ev_chan,
   input wire logic        ev_analog,
   input wire logic [2:0]  ev_kind,
   input wire logic        ev_call
);
   default clocking @(posedge clk_sys); endclocking
   default disable iff (rst);
   logic legal;
   assign legal = di_func == 8'h02 && di_addr <= 4'h7;
   a_di_answer: assert property (di_rd |=> di_valid)
      else $error("read not answered");
   a_di_refuse: assert property (di_rd && !legal |=> di_err)
      else $error("bad read not refused");
   a_di_accept: assert property (di_rd && legal |=> !di_err)
      else $error("good read refused");
   a_di_bit: assert property (di_rd && legal |=>
      $stable(din_state) -> di_bit == din_state[$past(di_addr)])
      else $error("read bit differs from input state");
   a_din_track: assert property ((din_closed == $past(din_closed))[*5] |->
      din_state == din_closed)
      else $error("input state does not follow pins");
   a_total_call: assert property (ev_valid && ev_kind == IAC_EV_TOTAL |->
      ev_call && ev_chan == 4'h0 && !ev_analog)
      else $error("total event malformed");
   a_total_reload: assert property (ev_valid && ev_kind == IAC_EV_TOTAL |->
      count_value == count_initial)
      else $error("counter not reloaded");
   a_step_chan: assert property (ev_valid && ev_kind == IAC_EV_STEP |->
      ev_chan == 4'h0 && !ev_call && !ev_analog)
      else $error("step event malformed");
   a_ev_kind: assert property (ev_valid |->
      ev_kind != IAC_EV_NONE && (ev_analog || ev_chan < 4'h8))
      else $error("event without kind or channel");
   a_arm_switch: assert property (!$past(rst, 2) && $changed(armed) |->
      din_type_cfg[5:3] == 3'h5)
      else $error("arm changed without switch channel");
endmodule

bind iac_top iac_chk chk (.clk_sys, .rst, .din_closed, .din_type_cfg, .count_initial,
   .di_func, .di_addr, .di_rd, .di_valid, .di_bit, .di_err, .din_state, .armed,
   .count_value, .ev_valid, .ev_chan, .ev_analog, .ev_kind, .ev_call);

// File: test/iac_field.sv
// Field model: contact detectors with chatter and one analog transducer
`timescale 1ns/1ns
module iac_field (
   // Clock
   input  wire logic               clk_sys,
   // Requested field state
   input  wire logic [7:0]         contact_req,
   input  wire logic [7:0]         bounce_req,
   input  wire logic signed [31:0] level_req,
   // Pins
   output logic [7:0]              din_closed,
   output logic [191:0]            analog_input
);
   logic tog_r = 1'b0;
   initial din_closed = 8'h00;
   // closed reads 1, chatter flips it every cycle
   always @(posedge clk_sys) begin
      tog_r <= ~tog_r;
      din_closed <= #1 contact_req ^ (bounce_req & {8{tog_r}});
   end
   assign analog_input = {160'h0, level_req};
endmodule

// File: test/iac_top_test.sv
// Testbench: contact, counter, analog and discrete read scenarios
`timescale 1ns/1ns
module iac_top_test;
   import iac_pkg::*;
   logic               clk_sys = 1'b0, rst = 1'b1, di_rd = 1'b0;
   logic               count_en = 1'b1, arm_at_reset = 1'b1;
   logic               di_valid, di_bit, di_err, armed, siren_start, ev_valid, ev_analog, ev_call;
   logic [7:0]         contact_req = 8'h00, bounce_req = 8'h00, di_func = 8'h02, pat;
   logic [7:0]         din_always_armed_flag = 8'h00, din_recovery_en = 8'h00;
   logic [7:0]         din_siren_en = 8'h00, din_closed, din_state;
   logic [23:0]        din_type_cfg = 24'h00_0000;
   logic [127:0]       din_verify_cfg = {8{16'h0004}};
   logic [31:0]        count_initial = 32'h0000_000A, count_step = 32'h0000_000C;
   logic [31:0]        count_total = 32'h0000_000D, count_value;
   logic signed [31:0] level_req = 32'h0000_0000;
   logic [191:0]       ain_thr_high = {6{32'h0000_0064}}, ain_thr_low = {6{32'hFFFF_FF9C}};
   logic [191:0]       analog_input;
   logic [11:0]        ain_type_cfg = 12'h000;
   logic [5:0]         ain_always_armed_flag = 6'h00, ain_recovery_en = 6'h00;
   logic [5:0]         ain_siren_en = 6'h00;
   logic [3:0]         di_addr = 4'h0, ev_chan;
   logic [2:0]         ev_kind;
   logic [1:0]         rexp;
   logic [1:0]         rq[$];
   logic [8:0]         eq[$];
   int                 n_fail = 0, n_tests = 0, n_cyc = 0, n_siren = 0;

   iac_field field (.clk_sys, .contact_req, .bounce_req, .level_req, .din_closed,
      .analog_input);
   iac_top #(.VERIFY_TICK(2)) uut (.clk_sys, .rst, .din_closed, .din_type_cfg,
      .din_verify_cfg, .din_always_armed_flag, .din_recovery_en, .din_siren_en, .count_en,
      .count_initial, .count_step, .count_total, .arm_at_reset, .analog_input, .ain_type_cfg,
      .ain_thr_high, .ain_thr_low, .ain_always_armed_flag, .ain_recovery_en, .ain_siren_en,
      .di_func, .di_addr, .di_rd, .di_valid, .di_bit, .di_err, .din_state, .armed,
      .count_value, .siren_start, .ev_valid, .ev_chan, .ev_analog, .ev_kind, .ev_call);

   always #5 clk_sys = ~clk_sys;

   task chk(input logic [31:0] seen, input logic [31:0] want);
      n_tests++;
      if (seen !== want) begin
         n_fail++;
         $display("BAD %0t seen %0h want %0h", $time, seen, want);
      end
   endtask
   task cyc(input int n);
      repeat (n) @(posedge clk_sys);
      #1;
   endtask
   // Request held through the taking edge; caller drops it after the last one
   task rd(input logic [7:0] f, input logic [3:0] a, input logic [1:0] e);
      rq.push_back(e);
      di_func = f;
      di_addr = a;
      di_rd = 1'b1;
      cyc(1);
   endtask
   // Held far beyond the verify time so the filter must accept it
   task put(input int ch, input logic v);
      contact_req[ch] = v;
      cyc(40);
   endtask
   task ex(input logic an, input logic [3:0] ch, input logic [2:0] k, input logic call);
      eq.push_back({an, ch, k, call});
   endtask
   task close_out;
      $display("tests %0d fails %0d", n_tests, n_fail);
      if (n_fail == 0 && n_tests > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask

   // Oldest note is compared with every answer and event
   always @(negedge clk_sys) begin
      n_cyc++;
      if (siren_start === 1'b1) n_siren++;
      if (di_valid === 1'b1) begin
         rexp = rq.size() != 0 ? rq.pop_front() : 2'bxx;
         chk(di_err, rexp[1]);
         if (!rexp[1]) chk(di_bit, rexp[0]);
      end
      if (ev_valid === 1'b1) chk({ev_analog, ev_chan, ev_kind, ev_call},
         eq.size() != 0 ? eq.pop_front() : 9'bx);
      if (n_cyc == 3000) begin
         n_fail++;
         close_out;
      end
   end

   initial begin
      pat = 8'($urandom(15534));
      cyc(5);
      rst = 1'b0;
      cyc(3);
      chk(armed, 1'b1);
      contact_req = pat;
      cyc(8);
      for (int i = 0; i < 8; i++) rd(8'h02, 4'(i), {1'b0, pat[i]});
      rd(8'h01, 4'h0, 2'b10);
      rd(8'h02, 4'h8, 2'b10);
      di_rd = 1'b0;
      contact_req = 8'h08;
      cyc(20);
      chk(din_state, 8'h08);
      din_type_cfg = {3'h0, 3'h2, 3'h0, 3'h3, 3'h1, 3'h2, 3'h5, 3'h4};
      din_always_armed_flag = 8'h41;
      din_recovery_en = 8'h04;
      din_siren_en = 8'h08;
      cyc(20);
      chk(count_value, count_initial);
      bounce_req = 8'($urandom() | 32'h0000_0004) & 8'h24;
      cyc(40);
      bounce_req = 8'h00;
      cyc(20);
      ex(1'b0, 4'h2, IAC_EV_ALARM, 1'b0);
      put(2, 1'b1);
      ex(1'b0, 4'h2, IAC_EV_RECOVERY, 1'b0);
      put(2, 1'b0);
      ex(1'b0, 4'h3, IAC_EV_ALARM, 1'b0);
      put(3, 1'b0);
      put(3, 1'b1);
      ex(1'b0, 4'h4, IAC_EV_CHANGE, 1'b0);
      put(4, 1'b1);
      ex(1'b0, 4'h4, IAC_EV_CHANGE, 1'b0);
      put(4, 1'b0);
      put(5, 1'b1);
      put(5, 1'b0);
      put(0, 1'b1);
      put(0, 1'b0);
      chk(count_value, 32'h0000_000B);
      ex(1'b0, 4'h0, IAC_EV_STEP, 1'b0);
      put(0, 1'b1);
      put(0, 1'b0);
      ex(1'b0, 4'h0, IAC_EV_TOTAL, 1'b1);
      put(0, 1'b1);
      put(0, 1'b0);
      chk(count_value, count_initial);
      put(1, 1'b1);
      chk(armed, 1'b0);
      put(1, 1'b0);
      put(2, 1'b1);
      put(2, 1'b0);
      ex(1'b0, 4'h6, IAC_EV_ALARM, 1'b0);
      put(6, 1'b1);
      put(6, 1'b0);
      ain_type_cfg = 12'h001;
      ain_always_armed_flag = 6'h01;
      ain_recovery_en = 6'h01;
      cyc(5);
      ex(1'b1, 4'h0, IAC_EV_HIGH, 1'b0);
      level_req = 32'h0000_00C8;
      cyc(10);
      ex(1'b1, 4'h0, IAC_EV_RECOVERY, 1'b0);
      level_req = 32'h0000_0000;
      cyc(10);
      ex(1'b1, 4'h0, IAC_EV_LOW, 1'b0);
      level_req = 32'hFFFF_FF38;
      cyc(30);
      chk(eq.size(), 0);
      chk(n_siren, 1);
      close_out;
   end
endmodule

// File: verilog/iac_ain_cmp.sv
// Analog threshold compare for one channel
`timescale 1ns/1ns
module iac_ain_cmp
   import iac_pkg::*;
#(
   parameter int W = IAC_AIN_W
) (
   // Clock and reset
   input  wire logic                clk_sys,
   input  wire logic                rst,
   // Configuration
   input  wire logic                enable,
   input  wire logic signed [W-1:0] thr_high,
   input  wire logic signed [W-1:0] thr_low,
   // Value and result
   input  wire logic signed [W-1:0] value,
   output logic                     high,
   output logic                     low
);

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         high <= 1'b0;
         low  <= 1'b0;
      end else begin
         high <= enable && (value > thr_high);
         low  <= enable && (value < thr_low);
      end
   end

endmodule

// File: verilog/iac_filter.sv
// Persistence filter: holds the level change until it lasts past the verify time
`timescale 1ns/1ns
module iac_filter
   import iac_pkg::*;
#(
   parameter int VERIFY_W = IAC_VERIFY_W
) (
   // Clock and reset
   input  wire logic                clk_sys,
   input  wire logic                rst,
   // Control
   input  wire logic                tick,
   input  wire logic [VERIFY_W-1:0] verify_time,
   // Data
   input  wire logic                raw,
   output logic                     level
);

   logic [VERIFY_W-1:0] age_r;

   // Level accepted only after raw has differed for longer than the verify time
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         age_r <= '0;
         level <= 1'b0;
      end else if (raw == level) begin
         age_r <= '0;
      end else if (age_r > verify_time) begin
         level <= raw;
         age_r <= '0;
      end else if (tick) begin
         age_r <= age_r + 1'b1;
      end
   end

endmodule

// File: verilog/iac_top.sv
// Input alarm evaluation, pulse counter and discrete input readout
`timescale 1ns/1ns
module iac_top
   import iac_pkg::*;
#(
   parameter int NUM_DIN        = IAC_NUM_DIN,
   parameter int NUM_AIN        = IAC_NUM_AIN,
   parameter int VERIFY_W       = IAC_VERIFY_W,
   parameter int COUNT_W        = IAC_COUNT_W,
   parameter int AIN_W          = IAC_AIN_W,
   parameter int VERIFY_TICK    = IAC_VERIFY_TICK_CYC
) (
   // Clock and reset
   input  wire logic                           clk_sys,
   input  wire logic                           rst,
   // Contact inputs, 1 = closed contact or low wet level
   input  wire logic [NUM_DIN-1:0]             din_closed,
   // Digital configuration
   input  wire logic [NUM_DIN*3-1:0]           din_type_cfg,
   input  wire logic [NUM_DIN*VERIFY_W-1:0]    din_verify_cfg,
   input  wire logic [NUM_DIN-1:0]             din_always_armed_flag,
   input  wire logic [NUM_DIN-1:0]             din_recovery_en,
   input  wire logic [NUM_DIN-1:0]             din_siren_en,
   // Pulse counter configuration
   input  wire logic                           count_en,
   input  wire logic [COUNT_W-1:0]             count_initial,
   input  wire logic [COUNT_W-1:0]             count_step,
   input  wire logic [COUNT_W-1:0]             count_total,
   // Arm control
   input  wire logic                           arm_at_reset,
   // Analog inputs and configuration
   input  wire logic [NUM_AIN*AIN_W-1:0]       analog_input,
   input  wire logic [NUM_AIN*2-1:0]           ain_type_cfg,
   input  wire logic [NUM_AIN*AIN_W-1:0]       ain_thr_high,
   input  wire logic [NUM_AIN*AIN_W-1:0]       ain_thr_low,
   input  wire logic [NUM_AIN-1:0]             ain_always_armed_flag,
   input  wire logic [NUM_AIN-1:0]             ain_recovery_en,
   input  wire logic [NUM_AIN-1:0]             ain_siren_en,
   // Discrete input read port
   input  wire logic [7:0]                     di_func,
   input  wire logic [3:0]                     di_addr,
   input  wire logic                           di_rd,
   output logic                                di_valid,
   output logic                                di_bit,
   output logic                                di_err,
   // Status
   output logic [NUM_DIN-1:0]                  din_state,
   output logic                                armed,
   output logic [COUNT_W-1:0]                  count_value,
   output logic                                siren_start,
   // Event port to messaging unit
   output logic                                ev_valid,
   output logic [IAC_CHAN_W-1:0]               ev_chan,
   output logic                                ev_analog,
   output logic [2:0]                          ev_kind,
   output logic                                ev_call
);

   // Read map and channel field serve at most eight inputs of each kind
   if (NUM_DIN < 2 || NUM_DIN > 8 || NUM_AIN < 1 || NUM_AIN > 8
       || VERIFY_TICK < 1) begin : g_bad_cfg
      $error("iac_top: unsupported parameter values");
   end

   function automatic iac_din_type din_type_of(input int ch);
      iac_din_type t;
      t = iac_din_type'(din_type_cfg[ch*3 +: 3]);
      // Counter and arm switch are legal only on their own channel
      if (t == IAC_DIN_COUNTER && ch != IAC_COUNTER_CH)
         t = IAC_DIN_DISABLED;
      if (t == IAC_DIN_ARMSW && ch != IAC_ARMSW_CH)
         t = IAC_DIN_DISABLED;
      return t;
   endfunction

   // Synchronisers for the contact pins
   logic [NUM_DIN-1:0] sync1_r;
   logic [NUM_DIN-1:0] sync2_r;
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         sync1_r <= '0;
         sync2_r <= '0;
      end else begin
         sync1_r <= din_closed;
         sync2_r <= sync1_r;
      end
   end

   // Verify time base tick
   logic [31:0] tick_cnt_r;
   logic        tick_r;
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         tick_cnt_r <= '0;
         tick_r     <= 1'b0;
      end else if (tick_cnt_r == 32'(VERIFY_TICK - 1)) begin
         tick_cnt_r <= '0;
         tick_r     <= 1'b1;
      end else begin
         tick_cnt_r <= tick_cnt_r + 32'h0000_0001;
         tick_r     <= 1'b0;
      end
   end

   // Filtered levels
   logic [NUM_DIN-1:0] filt;
   logic [NUM_DIN-1:0] filt_d_r;
   genvar g;
   generate
      for (g = 0; g < NUM_DIN; g++) begin : g_filt
         iac_filter #(.VERIFY_W(VERIFY_W)) u_filt (
            .clk_sys     (clk_sys),
            .rst         (rst),
            .tick        (tick_r),
            .verify_time (din_verify_cfg[g*VERIFY_W +: VERIFY_W]),
            .raw         (sync2_r[g]),
            .level       (filt[g])
         );
      end
   endgenerate

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         filt_d_r <= '0;
      end else begin
         filt_d_r <= filt;
      end
   end

   // discrete input state register, closed reads 1
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         din_state <= '0;
      end else begin
         din_state <= sync2_r;
      end
   end

   // Per-channel digital event decode
   logic [NUM_DIN-1:0] d_alarm;
   logic [NUM_DIN-1:0] d_recov;
   logic [NUM_DIN-1:0] d_change;
   logic [NUM_DIN-1:0] d_gate;
   always_comb begin
      for (int i = 0; i < NUM_DIN; i++) begin
         logic rise;
         logic fall;
         rise = filt[i] && !filt_d_r[i];
         fall = !filt[i] && filt_d_r[i];
         d_gate[i]   = armed || din_always_armed_flag[i];
         d_alarm[i]  = 1'b0;
         d_recov[i]  = 1'b0;
         d_change[i] = 1'b0;
         unique case (din_type_of(i))
            IAC_DIN_NC: begin
               d_alarm[i] = fall;
               d_recov[i] = rise && din_recovery_en[i];
            end
            IAC_DIN_NO: begin
               d_alarm[i] = rise;
               d_recov[i] = fall && din_recovery_en[i];
            end
            IAC_DIN_CHANGE: begin
               d_change[i] = rise || fall;
            end
            // disabled and special types raise no plain alarm
            default: begin
            end
         endcase
      end
   end

   // arm switch on channel one, arm state
   logic arm_init_r;
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         armed      <= 1'b0;
         arm_init_r <= 1'b0;
      end else if (!arm_init_r) begin
         armed      <= arm_at_reset;
         arm_init_r <= 1'b1;
      end else if (din_type_of(IAC_ARMSW_CH) == IAC_DIN_ARMSW
                   && filt[IAC_ARMSW_CH] && !filt_d_r[IAC_ARMSW_CH]) begin
         armed <= !armed;
      end
   end

   // Pulse counter
   logic cnt_mode;
   logic cnt_pulse;
   logic cnt_loaded_r;
   logic step_hit_r;
   logic total_hit_r;
   assign cnt_mode  = (din_type_of(IAC_COUNTER_CH) == IAC_DIN_COUNTER) && count_en;
   assign cnt_pulse = cnt_mode && filt[IAC_COUNTER_CH] && !filt_d_r[IAC_COUNTER_CH];

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         count_value  <= '0;
         cnt_loaded_r <= 1'b0;
         step_hit_r   <= 1'b0;
         total_hit_r  <= 1'b0;
      end else begin
         step_hit_r  <= 1'b0;
         total_hit_r <= 1'b0;
         if (!cnt_mode) begin
            cnt_loaded_r <= 1'b0;
         end else if (!cnt_loaded_r) begin
            count_value  <= count_initial;
            cnt_loaded_r <= 1'b1;
         end else if (cnt_pulse) begin
            if (count_value + 1'b1 == count_total) begin
               count_value <= count_initial;
               total_hit_r <= 1'b1;
            end else begin
               count_value <= count_value + 1'b1;
            end
            if (count_value + 1'b1 == count_step)
               step_hit_r <= 1'b1;
         end
      end
   end

   // Analog channels
   logic [NUM_AIN-1:0] a_high;
   logic [NUM_AIN-1:0] a_low;
   logic [NUM_AIN-1:0] a_high_d_r;
   logic [NUM_AIN-1:0] a_low_d_r;
   generate
      for (g = 0; g < NUM_AIN; g++) begin : g_ain
         iac_ain_cmp #(.W(AIN_W)) u_cmp (
            .clk_sys  (clk_sys),
            .rst      (rst),
            .enable   (iac_ain_type'(ain_type_cfg[g*2 +: 2]) != IAC_AIN_DISABLED),
            .thr_high (ain_thr_high[g*AIN_W +: AIN_W]),
            .thr_low  (ain_thr_low[g*AIN_W +: AIN_W]),
            .value    (analog_input[g*AIN_W +: AIN_W]),
            .high     (a_high[g]),
            .low      (a_low[g])
         );
      end
   endgenerate

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         a_high_d_r <= '0;
         a_low_d_r  <= '0;
      end else begin
         a_high_d_r <= a_high;
         a_low_d_r  <= a_low;
      end
   end

   // Pending event flags; set wins over the clear from dispatch
   logic [NUM_DIN-1:0] p_alarm_r;
   logic [NUM_DIN-1:0] p_recov_r;
   logic [NUM_DIN-1:0] p_change_r;
   logic               p_step_r;
   logic               p_total_r;
   logic [NUM_AIN-1:0] p_high_r;
   logic [NUM_AIN-1:0] p_low_r;
   logic [NUM_AIN-1:0] p_arec_r;

   // Dispatch selection, one event per cycle in fixed priority
   logic                  sel_v;
   logic [IAC_CHAN_W-1:0] sel_ch;
   logic                  sel_an;
   iac_event_type         sel_k;
   always_comb begin
      sel_v  = 1'b0;
      sel_ch = '0;
      sel_an = 1'b0;
      sel_k  = IAC_EV_NONE;
      if (p_total_r) begin
         sel_v = 1'b1;
         sel_k = IAC_EV_TOTAL;
      end else if (p_step_r) begin
         sel_v = 1'b1;
         sel_k = IAC_EV_STEP;
      end
      for (int i = 0; i < NUM_DIN; i++) begin
         if (!sel_v && (p_alarm_r[i] || p_change_r[i] || p_recov_r[i])) begin
            sel_v  = 1'b1;
            sel_ch = IAC_CHAN_W'(i);
            sel_k  = p_alarm_r[i] ? IAC_EV_ALARM :
                     p_change_r[i] ? IAC_EV_CHANGE : IAC_EV_RECOVERY;
         end
      end
      for (int i = 0; i < NUM_AIN; i++) begin
         if (!sel_v && (p_high_r[i] || p_low_r[i] || p_arec_r[i])) begin
            sel_v  = 1'b1;
            sel_an = 1'b1;
            sel_ch = IAC_CHAN_W'(i);
            sel_k  = p_high_r[i] ? IAC_EV_HIGH :
                     p_low_r[i] ? IAC_EV_LOW : IAC_EV_RECOVERY;
         end
      end
   end

   // Pending flag update
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         p_alarm_r  <= '0;
         p_recov_r  <= '0;
         p_change_r <= '0;
         p_step_r   <= 1'b0;
         p_total_r  <= 1'b0;
         p_high_r   <= '0;
         p_low_r    <= '0;
         p_arec_r   <= '0;
      end else begin
         for (int i = 0; i < NUM_DIN; i++) begin
            p_alarm_r[i]  <= (p_alarm_r[i] && !(sel_v && !sel_an && sel_ch == i
                              && sel_k == IAC_EV_ALARM)) || (d_alarm[i] && d_gate[i]);
            p_change_r[i] <= (p_change_r[i] && !(sel_v && !sel_an && sel_ch == i
                              && sel_k == IAC_EV_CHANGE)) || (d_change[i] && d_gate[i]);
            p_recov_r[i]  <= (p_recov_r[i] && !(sel_v && !sel_an && sel_ch == i
                              && sel_k == IAC_EV_RECOVERY)) || (d_recov[i] && d_gate[i]);
         end
         p_step_r  <= (p_step_r && !(sel_v && sel_k == IAC_EV_STEP))
                      || (step_hit_r && d_gate[IAC_COUNTER_CH]);
         p_total_r <= (p_total_r && !(sel_v && sel_k == IAC_EV_TOTAL))
                      || (total_hit_r && d_gate[IAC_COUNTER_CH]);
         for (int i = 0; i < NUM_AIN; i++) begin
            p_high_r[i] <= (p_high_r[i] && !(sel_v && sel_an && sel_ch == i
                            && sel_k == IAC_EV_HIGH))
                           || (a_high[i] && !a_high_d_r[i]
                               && (armed || ain_always_armed_flag[i]));
            p_low_r[i]  <= (p_low_r[i] && !(sel_v && sel_an && sel_ch == i
                            && sel_k == IAC_EV_LOW))
                           || (a_low[i] && !a_low_d_r[i]
                               && (armed || ain_always_armed_flag[i]));
            p_arec_r[i] <= (p_arec_r[i] && !(sel_v && sel_an && sel_ch == i
                            && sel_k == IAC_EV_RECOVERY))
                           || ((a_high_d_r[i] || a_low_d_r[i]) && !a_high[i] && !a_low[i]
                               && ain_recovery_en[i] && (armed || ain_always_armed_flag[i]));
         end
      end
   end

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         ev_valid  <= 1'b0;
         ev_chan   <= '0;
         ev_analog <= 1'b0;
         ev_kind   <= IAC_EV_NONE;
         ev_call   <= 1'b0;
      end else begin
         ev_valid  <= sel_v;
         ev_chan   <= sel_ch;
         ev_analog <= sel_an;
         ev_kind   <= sel_k;
         // total asks for call and message
         ev_call   <= sel_v && sel_k == IAC_EV_TOTAL;
      end
   end

   // siren start on gated trigger of a siren-flagged channel
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         siren_start <= 1'b0;
      end else begin
         siren_start <= |((d_alarm | d_change) & d_gate & din_siren_en)
                        | |(((a_high & ~a_high_d_r) | (a_low & ~a_low_d_r))
                            & ain_siren_en & (ain_always_armed_flag | {NUM_AIN{armed}}));
      end
   end

   // discrete input read, addresses 0 to 7, function 02
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         di_valid <= 1'b0;
         di_bit   <= 1'b0;
         di_err   <= 1'b0;
      end else begin
         di_valid <= di_rd;
         di_bit   <= 1'b0;
         di_err   <= 1'b0;
         if (di_rd) begin
            if (di_func == IAC_FC_READ_DISCRETE && di_addr <= IAC_DIN7_STATE_ADDR
                && di_addr >= IAC_DIN0_STATE_ADDR && int'(di_addr) < NUM_DIN)
               di_bit <= din_state[di_addr[2:0]];
            else
               di_err <= 1'b1;
         end
      end
   end

   // climate sensor limits are fixed constants in the package

endmodule
